/* design/frtc_defines.svh */
`ifndef FRTC_DEFINES_SVH
`define FRTC_DEFINES_SVH
`define FRTC_ADDR_CNT_HI 4'h0
`define FRTC_ADDR_CNT_LO 4'h1
`define FRTC_ADDR_CMP_HI 4'h2
`define FRTC_ADDR_CMP_LO 4'h3
`define FRTC_ADDR_TSC 4'h4
`define FRTC_ADDR_TCR 4'h5
`define FRTC_ADDR_TOC 4'h6
`define FRTC_ADDR_CAP_BIT 3
`define FRTC_TCR_RESET 8'h00
`define FRTC_TOC_RESET 8'hE0
`define FRTC_TOC_RSVD_ONES 3'h7
`define FRTC_TSC_CCLR_BIT 0
`define FRTC_PRE_MASK_DIV2 5'h01
`define FRTC_PRE_MASK_DIV8 5'h07
`define FRTC_PRE_MASK_DIV32 5'h1F
`define FRTC_CNT_MAX 16'hFFFF
`define FRTC_CAP_A 0
`define FRTC_CAP_B 1
`define FRTC_CAP_C 2
`define FRTC_CAP_D 3
`endif

/* design/frtc_pkg.sv */
package frtc_pkg;
   // counter clock source
   typedef enum logic [1:0] {
      CKS_DIV2 = 2'b00,
      CKS_DIV8 = 2'b01,
      CKS_DIV32 = 2'b10,
      CKS_EXT = 2'b11
   } frtc_cks_t;
   // timer control layout, bit 7 down to bit 0
   typedef struct packed {
      logic edge_sel_a;
      logic edge_sel_b;
      logic edge_sel_c;
      logic edge_sel_d;
      logic buffer_en_a;
      logic buffer_en_b;
      frtc_cks_t clk_sel;
   } frtc_tcr_t;
   // compare output control layout
   typedef struct packed {
      logic [2:0] rsvd;
      logic compare_reg_select;
      logic out_en_a;
      logic out_en_b;
      logic out_level_a;
      logic out_level_b;
   } frtc_toc_t;
   // cpu byte access
   typedef struct packed {
      logic [3:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } frtc_bus_t;
endpackage

/* design/frtc_top.sv */
`timescale 1ns/100ps
`include "frtc_defines.svh"
module frtc_top #(
   parameter int CH = 4,
   parameter int PRE_W = 5
) (
   // clock and reset
   input logic I_REF_CLK,
   input logic I_RST_N,
   input logic I_STANDBY,
   // cpu byte bus
   input frtc_pkg::frtc_bus_t I_BUS,
   output logic [7:0] O_RDATA,
   // pins
   input logic [CH-1:0] I_CAPTURE_IN,
   input logic I_EXT_COUNT_CLK,
   output logic O_COMPARE_OUT_A,
   output logic O_COMPARE_OUT_B,
   output logic O_COMPARE_OE_A_N,
   output logic O_COMPARE_OE_B_N,
   // events
   output logic [CH-1:0] O_CAPTURE_EVT,
   output logic [1:0] O_MATCH_EVT,
   output logic O_OVERFLOW_EVT
);
   import frtc_pkg::*;

   frtc_tcr_t tcr_q;
   frtc_toc_t toc_q;
   logic clear_on_match_a_q;
   logic [7:0] latch_q;
   logic [15:0] cnt_q;
   logic [15:0] cmp_a_q;
   logic [15:0] cmp_b_q;
   logic [15:0] cap_q [CH];
   logic [PRE_W-1:0] pre_q;
   logic [2:0] ext_q;
   logic [CH-1:0] sync1_q;
   logic [CH-1:0] sync2_q;
   logic [CH-1:0] prev_q;
   logic [CH-1:0] cap_evt;
   logic out_a_q;
   logic out_b_q;
   logic tick;
   logic ext_rise;
   logic match_a;
   logic match_b;
   logic clr;
   logic wr_cnt_lo;
   logic wr_cmp_a_lo;
   logic wr_cmp_b_lo;
   logic cap_sel;
   logic [1:0] cap_idx;
   logic init;

   // decode of byte accesses
   assign init = !I_RST_N || I_STANDBY;
   assign cap_sel = I_BUS.addr[`FRTC_ADDR_CAP_BIT];
   assign cap_idx = I_BUS.addr[2:1];
   assign wr_cnt_lo = I_BUS.wr && I_BUS.addr == `FRTC_ADDR_CNT_LO;
   assign wr_cmp_a_lo = I_BUS.wr && I_BUS.addr == `FRTC_ADDR_CMP_LO
                        && !toc_q.compare_reg_select;
   assign wr_cmp_b_lo = I_BUS.wr && I_BUS.addr == `FRTC_ADDR_CMP_LO
                        && toc_q.compare_reg_select;

   // prescaler of the reference clock
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // external count clock synchroniser and edge memory
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         ext_q <= 3'h0;
      end else begin
         ext_q <= {ext_q[1:0], I_EXT_COUNT_CLK};
      end
   end
   assign ext_rise = ext_q[1] && !ext_q[2];

   // count enable from the selected source
   always_comb begin
      case (tcr_q.clk_sel)
         CKS_DIV2: tick = (pre_q & `FRTC_PRE_MASK_DIV2) == `FRTC_PRE_MASK_DIV2;
         CKS_DIV8: tick = (pre_q & `FRTC_PRE_MASK_DIV8) == `FRTC_PRE_MASK_DIV8;
         CKS_DIV32: tick = (pre_q & `FRTC_PRE_MASK_DIV32) == `FRTC_PRE_MASK_DIV32;
         CKS_EXT: tick = ext_rise;
         default: tick = 1'b0;
      endcase
   end

   // match in the last state before the increment; a lower write wins
   assign match_a = tick && cnt_q == cmp_a_q && !wr_cmp_a_lo;
   assign match_b = tick && cnt_q == cmp_b_q && !wr_cmp_b_lo;
   assign clr = match_a && clear_on_match_a_q;

   // free counter: clear beats write, write beats increment
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         cnt_q <= 16'h0000;
      end else if (clr) begin
         cnt_q <= 16'h0000;
      end else if (wr_cnt_lo) begin
         cnt_q <= {latch_q, I_BUS.wdata};
      end else if (tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // compare registers at one shared address
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         cmp_a_q <= 16'hFFFF;
         cmp_b_q <= 16'hFFFF;
      end else begin
         if (wr_cmp_a_lo) begin
            cmp_a_q <= {latch_q, I_BUS.wdata};
         end
         if (wr_cmp_b_lo) begin
            cmp_b_q <= {latch_q, I_BUS.wdata};
         end
      end
   end

   // control registers, cleared by reset or standby
   always_ff @(posedge I_REF_CLK) begin
      if (init) begin
         tcr_q <= `FRTC_TCR_RESET;
         toc_q <= `FRTC_TOC_RESET;
         clear_on_match_a_q <= 1'b0;
      end else if (I_BUS.wr) begin
         if (I_BUS.addr == `FRTC_ADDR_TCR) begin
            tcr_q <= I_BUS.wdata;
         end
         if (I_BUS.addr == `FRTC_ADDR_TOC) begin
            toc_q <= {`FRTC_TOC_RSVD_ONES, I_BUS.wdata[4:0]};
         end
         if (I_BUS.addr == `FRTC_ADDR_TSC) begin
            clear_on_match_a_q <= I_BUS.wdata[`FRTC_TSC_CCLR_BIT];
         end
      end
   end

   // capture pin synchronisers and edge detect per channel
   genvar g;
   generate
      for (g = 0; g < CH; g++) begin : g_cap
         always_ff @(posedge I_REF_CLK) begin
            if (!I_RST_N) begin
               sync1_q[g] <= 1'b0;
               sync2_q[g] <= 1'b0;
               prev_q[g] <= 1'b0;
            end else begin
               sync1_q[g] <= I_CAPTURE_IN[g];
               sync2_q[g] <= sync1_q[g];
               prev_q[g] <= sync2_q[g];
            end
         end
         // edge sel bit g sits at tcr bit 7-g
         assign cap_evt[g] = tcr_q[7-g] ? (sync2_q[g] && !prev_q[g])
                                        : (!sync2_q[g] && prev_q[g]);
      end
   endgenerate

   // capture registers with optional buffering of A into C and B into D
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         for (int i = 0; i < CH; i++) begin
            cap_q[i] <= 16'h0000;
         end
      end else begin
         if (cap_evt[`FRTC_CAP_A]) begin
            cap_q[`FRTC_CAP_A] <= cnt_q;
         end
         if (cap_evt[`FRTC_CAP_B]) begin
            cap_q[`FRTC_CAP_B] <= cnt_q;
         end
         if (tcr_q.buffer_en_a) begin
            if (cap_evt[`FRTC_CAP_A]) begin
               cap_q[`FRTC_CAP_C] <= cap_q[`FRTC_CAP_A];
            end
         end else if (cap_evt[`FRTC_CAP_C]) begin
            cap_q[`FRTC_CAP_C] <= cnt_q;
         end
         if (tcr_q.buffer_en_b) begin
            if (cap_evt[`FRTC_CAP_B]) begin
               cap_q[`FRTC_CAP_D] <= cap_q[`FRTC_CAP_B];
            end
         end else if (cap_evt[`FRTC_CAP_D]) begin
            cap_q[`FRTC_CAP_D] <= cnt_q;
         end
      end
   end

   // compare output levels set on match
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
      end else begin
         if (match_a) begin
            out_a_q <= toc_q.out_level_a;
         end
         if (match_b) begin
            out_b_q <= toc_q.out_level_b;
         end
      end
   end

   // pin drivers, low while disabled
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         O_COMPARE_OUT_A <= 1'b0;
         O_COMPARE_OUT_B <= 1'b0;
         O_COMPARE_OE_A_N <= 1'b1;
         O_COMPARE_OE_B_N <= 1'b1;
      end else begin
         O_COMPARE_OUT_A <= toc_q.out_en_a && out_a_q;
         O_COMPARE_OUT_B <= toc_q.out_en_b && out_b_q;
         O_COMPARE_OE_A_N <= !toc_q.out_en_a;
         O_COMPARE_OE_B_N <= !toc_q.out_en_b;
      end
   end

   // one-cycle event pulses
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         O_CAPTURE_EVT <= '0;
         O_MATCH_EVT <= 2'h0;
         O_OVERFLOW_EVT <= 1'b0;
      end else begin
         O_CAPTURE_EVT <= cap_evt;
         O_MATCH_EVT <= {match_b, match_a};
         O_OVERFLOW_EVT <= tick && !clr && !wr_cnt_lo && cnt_q == `FRTC_CNT_MAX;
      end
   end

   // holding latch: upper write stores, counter and capture upper reads keep lower byte
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         latch_q <= 8'h00;
      end else if (I_BUS.wr) begin
         if (cap_sel || I_BUS.addr == `FRTC_ADDR_CNT_HI
             || I_BUS.addr == `FRTC_ADDR_CMP_HI) begin
            latch_q <= I_BUS.wdata;
         end
      end else if (I_BUS.rd) begin
         if (cap_sel && !I_BUS.addr[0]) begin
            latch_q <= cap_q[cap_idx][7:0];
         end else if (I_BUS.addr == `FRTC_ADDR_CNT_HI) begin
            latch_q <= cnt_q[7:0];
         end
      end
   end

   // read data, registered; unmapped reads return zero
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         O_RDATA <= 8'h00;
      end else if (I_BUS.rd) begin
         if (cap_sel) begin
            O_RDATA <= I_BUS.addr[0] ? latch_q : cap_q[cap_idx][15:8];
         end else begin
            case (I_BUS.addr)
               `FRTC_ADDR_CNT_HI: O_RDATA <= cnt_q[15:8];
               `FRTC_ADDR_CNT_LO: O_RDATA <= latch_q;
               `FRTC_ADDR_CMP_HI: O_RDATA <= toc_q.compare_reg_select ? cmp_b_q[15:8]
                                                                    : cmp_a_q[15:8];
               `FRTC_ADDR_CMP_LO: O_RDATA <= toc_q.compare_reg_select ? cmp_b_q[7:0]
                                                                    : cmp_a_q[7:0];
               `FRTC_ADDR_TSC: O_RDATA <= {7'h00, clear_on_match_a_q};
               `FRTC_ADDR_TCR: O_RDATA <= tcr_q;
               `FRTC_ADDR_TOC: O_RDATA <= toc_q;
               default: O_RDATA <= 8'h00;
            endcase
         end
      end
   end
endmodule // frtc_top

/* bench/frtc_monitor.sv */
`timescale 1ns/100ps
// port-level checks on bus reads and compare pins
module frtc_monitor (
   // clock and reset
   input logic I_REF_CLK,
   input logic I_RST_N,
   input logic I_STANDBY,
   // bus
   input frtc_pkg::frtc_bus_t I_BUS,
   input logic [7:0] O_RDATA,
   // pins and events
   input logic O_COMPARE_OUT_A,
   input logic O_COMPARE_OUT_B,
   input logic O_COMPARE_OE_A_N,
   input logic O_COMPARE_OE_B_N,
   input logic [1:0] O_MATCH_EVT
);
   import frtc_pkg::*;
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);
   // reset quiets the read port and both enables
   a_rst_quiet: assert property (disable iff (1'b0)
      !I_RST_N |=> O_RDATA == 8'h00 && O_COMPARE_OE_A_N && O_COMPARE_OE_B_N)
      else $error("outputs active during reset");
   a_toc_rsvd_ones: assert property (
      I_BUS.rd && I_BUS.addr == 4'h6 |=> O_RDATA[7:5] == 3'h7)
      else $error("reserved output control bits not one");
   a_pin_a_off: assert property (O_COMPARE_OE_A_N |-> !O_COMPARE_OUT_A)
      else $error("compare pin a driven while disabled");
   a_pin_b_off: assert property (O_COMPARE_OE_B_N |-> !O_COMPARE_OUT_B)
      else $error("compare pin b driven while disabled");
   a_level_a_cause: assert property (
      $changed(O_COMPARE_OUT_A) && $stable(O_COMPARE_OE_A_N) |-> $past(O_MATCH_EVT[0]))
      else $error("pin a changed without match a");
   a_level_b_cause: assert property (
      $changed(O_COMPARE_OUT_B) && $stable(O_COMPARE_OE_B_N) |-> $past(O_MATCH_EVT[1]))
      else $error("pin b changed without match b");
   a_rdata_holds: assert property (!$past(I_BUS.rd) |-> $stable(O_RDATA))
      else $error("read data moved without a read");
   a_standby_tcr: assert property (
      $past(I_STANDBY) && I_STANDBY && I_BUS.rd && I_BUS.addr == 4'h5 |=> O_RDATA == 8'h00)
      else $error("timer control not cleared in standby");
   c_match_a: cover property (O_MATCH_EVT[0]);
   c_match_b: cover property (O_MATCH_EVT[1]);
   c_standby_rd: cover property (I_STANDBY && I_BUS.rd);
endmodule // frtc_monitor

/* bench/frtc_cpu.sv */
`timescale 1ns/100ps
// cpu side of the byte bus, one request per cycle
module frtc_cpu (
   // clock
   input logic i_clk,
   // bus
   input logic [7:0] i_rdata,
   output frtc_pkg::frtc_bus_t o_bus
);
   import frtc_pkg::*;
   // idle bus at time zero
   initial o_bus = '0;
   // step past an edge, then raise a request held to the next edge
   task put(input logic [3:0] a, input logic w, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_bus = '{a, w, !w, d};
   endtask
   // let the taking edge pass, then drop the strobes
   task idle;
      @(posedge i_clk);
      #1;
      o_bus = '{~o_bus.addr, 1'b0, 1'b0, ~o_bus.wdata};
   endtask
   task wr8(input logic [3:0] a, input logic [7:0] d);
      put(a, 1'b1, d);
      idle;
   endtask
   task rd8(input logic [3:0] a, output logic [7:0] d);
      put(a, 1'b0, 8'h00);
      idle;
      d = i_rdata;
   endtask
   // upper byte always goes first
   task wr16(input logic [3:0] a, input logic [15:0] v);
      put(a, 1'b1, v[15:8]);
      put(a + 4'h1, 1'b1, v[7:0]);
      idle;
   endtask
   task rd16(input logic [3:0] a, output logic [15:0] v);
      put(a, 1'b0, 8'h00);
      put(a + 4'h1, 1'b0, 8'h00);
      v[15:8] = i_rdata;
      idle;
      v[7:0] = i_rdata;
   endtask
endmodule // frtc_cpu

/* bench/tb_frtc_top.sv */
`timescale 1ns/100ps
// drives the timer control block through the cpu model
module tb_frtc_top;
   import frtc_pkg::*;
   logic clk;
   logic rst_n;
   logic stby;
   logic ext;
   logic [3:0] cap;
   frtc_bus_t bus;
   logic [7:0] rd;
   logic [3:0] pin;
   logic [7:0] b;
   logic [15:0] v;
   logic [15:0] w;
   logic [15:0] r;
   int failures;
   int samples_checked;
   logic [3:0] cevt;
   logic ovf;
   int ncap;
   int novf;
   int n0;
   frtc_top u_frtc_top (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_STANDBY(stby), .I_BUS(bus),
      .O_RDATA(rd), .I_CAPTURE_IN(cap), .I_EXT_COUNT_CLK(ext), .O_COMPARE_OUT_A(pin[3]),
      .O_COMPARE_OUT_B(pin[2]), .O_COMPARE_OE_A_N(pin[1]), .O_COMPARE_OE_B_N(pin[0]),
      .O_CAPTURE_EVT(cevt), .O_MATCH_EVT(), .O_OVERFLOW_EVT(ovf));
   // count capture pulses of all channels and overflow pulses each cycle
   always @(posedge clk) begin
      if (!rst_n) begin
         ncap <= 0;
         novf <= 0;
      end else begin
         ncap <= ncap + $countones(cevt);
         novf <= novf + ovf;
      end
   end
   frtc_cpu u_frtc_cpu (.i_clk(clk), .i_rdata(rd), .o_bus(bus));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task chk(input string n, input logic [15:0] e, input logic [15:0] s);
      samples_checked++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, s);
         failures++;
      end
   endtask
   task rdc(input string n, input logic [3:0] a, input logic [15:0] e);
      u_frtc_cpu.rd16(a, r);
      chk(n, e, r);
   endtask
   // pin change, then time for the synchronisers
   task pins(input logic [3:0] p);
      cap = p;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence
   initial begin
      {rst_n, stby, ext, cap, failures, samples_checked} = '0;
      cap = 4'hF;
      v = 16'($urandom(32'hC9F44E9B));
      repeat (8) @(posedge clk);
      #1;
      rst_n = 1'b1;
      u_frtc_cpu.rd8(4'h6, b);
      chk("output control", 16'h00E0, {8'h00, b});
      u_frtc_cpu.rd8(4'h5, b);
      chk("timer control", 16'h0000, {8'h00, b});
      u_frtc_cpu.wr8(4'h5, 8'h03);
      u_frtc_cpu.wr16(4'h0, v);
      rdc("counter", 4'h0, v);
      for (int k = 0; k < 3; k++) begin
         u_frtc_cpu.wr8(4'h5, 8'(k));
         u_frtc_cpu.rd16(4'h0, w);
         repeat (60) @(posedge clk);
         #1;
         rdc("count step", 4'h0, w + 16'(64 >> (2 * k + 1)));
      end
      $display("test reset and divider done");
      for (int ch = 0; ch < 2; ch++) begin
         w = 16'($urandom);
         u_frtc_cpu.wr8(4'h5, 8'h03);
         u_frtc_cpu.wr16(4'h0, v);
         pins(4'hF ^ (4'h1 << ch));
         u_frtc_cpu.wr16(4'h0, w);
         pins(4'hF ^ (4'h5 << ch));
         rdc("capture main", 4'(8 + 2 * ch), v);
         rdc("capture own", 4'(12 + 2 * ch), w);
         pins(4'hF);
         u_frtc_cpu.wr8(4'h5, 8'h03 | (8'h88 >> ch));
         u_frtc_cpu.wr16(4'h0, ~v);
         pins(4'hF ^ (4'h1 << ch));
         pins(4'hF);
         rdc("buffered main", 4'(8 + 2 * ch), ~v);
         rdc("buffered copy", 4'(12 + 2 * ch), v);
         pins(4'hF ^ (4'h4 << ch));
         pins(4'hF);
         rdc("buffer kept", 4'(12 + 2 * ch), v);
      end
      chk("capture events", 16'd8, 16'(ncap));
      $display("test capture done");
      u_frtc_cpu.wr8(4'h6, 8'h1F);
      u_frtc_cpu.rd8(4'h6, b);
      chk("output control", 16'h00FF, {8'h00, b});
      stby = 1'b1;
      u_frtc_cpu.rd8(4'h5, b);
      stby = 1'b0;
      chk("standby timer control", 16'h0000, {8'h00, b});
      u_frtc_cpu.rd8(4'h6, b);
      chk("standby output control", 16'h00E0, {8'h00, b});
      $display("test standby done");
      u_frtc_cpu.wr8(4'h5, 8'h03);
      u_frtc_cpu.wr16(4'h0, 16'h0010);
      u_frtc_cpu.wr16(4'h2, 16'h0012);
      u_frtc_cpu.wr8(4'h6, 8'h1F);
      u_frtc_cpu.wr16(4'h2, 16'h0011);
      u_frtc_cpu.wr8(4'h4, 8'h01);
      rdc("counter", 4'h0, 16'h0010);
      u_frtc_cpu.rd8(4'h3, b);
      chk("compare b low", 16'h0011, {8'h00, b});
      u_frtc_cpu.wr8(4'h6, 8'h0F);
      rdc("compare a", 4'h2, 16'h0012);
      for (int i = 0; i < 6; i++) begin
         ext = ~ext;
         repeat (4) @(posedge clk);
         #1;
      end
      rdc("cleared counter", 4'h0, 16'h0000);
      chk("compare pins", 16'h000C, {12'h000, pin});
      u_frtc_cpu.wr8(4'h6, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk("disabled pins", 16'h0003, {12'h000, pin});
      // two external rises carry the counter through its top value
      u_frtc_cpu.wr16(4'h0, 16'hFFFE);
      n0 = novf;
      for (int i = 0; i < 4; i++) begin
         ext = ~ext;
         repeat (4) @(posedge clk);
         #1;
      end
      chk("overflow event", 16'(n0 + 1), 16'(novf));
      rdc("wrapped counter", 4'h0, 16'h0000);
      $display("test compare done");
      end_sim;
   end
endmodule // tb_frtc_top
bind frtc_top frtc_monitor u_frtc_monitor (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
   .I_STANDBY(I_STANDBY), .I_BUS(I_BUS), .O_RDATA(O_RDATA), .O_COMPARE_OUT_A(O_COMPARE_OUT_A),
   .O_COMPARE_OUT_B(O_COMPARE_OUT_B), .O_COMPARE_OE_A_N(O_COMPARE_OE_A_N),
   .O_COMPARE_OE_B_N(O_COMPARE_OE_B_N), .O_MATCH_EVT(O_MATCH_EVT));
